// [common/sim_regs.vh]
`ifndef SIM_REGS_VH
`define SIM_REGS_VH
// ----------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define SIM_OFF_CTRL      3'h0
`define SIM_OFF_TXBUF     3'h1
`define SIM_OFF_RXBUF     3'h2
`define SIM_OFF_STATUS    3'h3
`define SIM_OFF_BAUD      3'h4
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define SIM_CTRL_TWO_WIRE 0
`define SIM_CTRL_ALT_ORD  1
`define SIM_CTRL_CKPHASE  2
`define SIM_CTRL_AUTOCND  3
`define SIM_CTRL_ACK_OE   4
`define SIM_CTRL_ACK_VAL  5
`define SIM_CTRL_STINIT   6
`define SIM_CTRL_ACKTRIG  7
`define SIM_CTRL_MPFMT    8
`define SIM_CTRL_MULTIPROC_INT_ENABLE     9
`define SIM_CTRL_EXTCLK   10
`define SIM_CTRL_CLKWAIT  11
`define SIM_CTRL_MODE_LO  12
`define SIM_CTRL_MODE_HI  14
`define SIM_CTRL_RESET    16'h0000
// Serial mode field codes for multiprocessor frames.
`define SIM_MODE_MP7      3'h4
`define SIM_MODE_MP8      3'h5
// ----------------------------------------------------------------------
// Receive buffer and status fields
// ----------------------------------------------------------------------
`define SIM_RX_RECEIVED_MULTIPROC_FLAG       9
`define SIM_RX_FER        10
`define SIM_RX_OER        11
`define SIM_ST_TXEMPTY    0
`define SIM_ST_RXDONE     1
`define SIM_ST_ACK        2
`define SIM_ST_NACK       3
`define SIM_ST_START      4
`define SIM_ST_STOP       5
`define SIM_ST_BUSY       6
`define SIM_ST_W1C_MASK   16'h003C
`define SIM_BAUD_RESET    8'h0F
`define SIM_NINTH_BIT     4'h9
`define SIM_EIGHTH_BIT    4'h8
`endif

// [rtl/sim_sync.v]
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Two-stage synchroniser for pins from outside the clock domain
// ----------------------------------------------------------------------
module sim_sync #(
  parameter WIDTH = 3
) (
  input  wire             clk,
  input  wire             srst,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;

  // Idle lines sit high, so reset to ones avoids a false start condition.
  always @(posedge clk) begin
    if (srst) begin
      meta_reg <= {WIDTH{1'b1}};
      sync_out <= {WIDTH{1'b1}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // sim_sync

// [rtl/sim_async_rx.v]
`timescale 1ns/100ps
`include "sim_regs.vh"
// ----------------------------------------------------------------------
// Asynchronous frame receiver: start, 7 or 8 data bits LSB first,
// one multiprocessor bit, one stop bit. No parity is ever checked.
// ----------------------------------------------------------------------
module sim_async_rx (
  input  wire       clk,
  input  wire       srst,
  input  wire       rx_en,
  input  wire       rxd,
  input  wire       eight_bit,
  input  wire [7:0] baud_div,
  output reg        done,
  output reg  [7:0] data,
  output reg        mp_bit,
  output reg        frame_err
);
  localparam IDLE = 2'h0;
  localparam SHIFT = 2'h1;
  localparam STOP = 2'h2;

  reg [1:0] state_reg;
  reg [7:0] tick_reg;
  reg [3:0] bit_reg;
  reg [8:0] shift_reg;
  wire      mid = (tick_reg == {1'b0, baud_div[7:1]});
  wire      last = (tick_reg == baud_div);
  wire [3:0] nbits = eight_bit ? 4'h9 : 4'h8;

  // Bit timing counts baud_div+1 clocks per bit and samples mid-bit.
  always @(posedge clk) begin
    if (srst) begin
      state_reg <= IDLE;
      tick_reg  <= 8'h00;
      bit_reg   <= 4'h0;
      shift_reg <= 9'h000;
      done      <= 1'b0;
      data      <= 8'h00;
      mp_bit    <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      done     <= 1'b0;
      tick_reg <= last ? 8'h00 : tick_reg + 8'h01;
      case (state_reg)
        IDLE: begin
          tick_reg <= 8'h00;
          bit_reg  <= 4'h0;
          if (rx_en && !rxd) begin
            state_reg <= SHIFT;
          end
        end
        SHIFT: begin
          if (mid && bit_reg == 4'h0 && rxd) begin
            state_reg <= IDLE;          // Glitch, not a start bit.
          end else if (mid && bit_reg != 4'h0) begin
            shift_reg <= {rxd, shift_reg[8:1]};
          end
          if (last) begin
            bit_reg <= bit_reg + 4'h1;
            if (bit_reg == nbits) begin
              state_reg <= STOP;
            end
          end
        end
        STOP: begin
          if (mid) begin
            done      <= 1'b1;
            frame_err <= !rxd;
            mp_bit    <= shift_reg[8];
            data      <= eight_bit ? shift_reg[7:0]
                                   : {1'b0, shift_reg[7:1]};
            state_reg <= IDLE;
          end
        end
        default: begin
          state_reg <= IDLE;
        end
      endcase
    end
  end
endmodule // sim_async_rx

// [rtl/sim_top.v]
`timescale 1ns/100ps
`include "sim_regs.vh"
// ----------------------------------------------------------------------
// Serial unit: two-wire receive layout, ACK/NACK, start-initialise and
// asynchronous multiprocessor reception.
// ----------------------------------------------------------------------
// Overview of operation
// - Normal order: bits one to eight land in buffer b7..b0; ninth is ack.
// - Alternate order: bits one to seven in b6..b0, eighth bit in b8.
// - Alternate order with phase select 1: ninth rising edge restores layout.
// - Auto conditions off and ack output on: drive ack data onto SDA.
// - Normal order: SDA sampled at ninth rising edge, high NACK, low ACK.
// - Ack trigger source chosen: detected ack requests a controller transfer.
// - Start with init: reload tx shifter from buffer, hold pin, then send.
// - Start with init: clear rx shifter, receive from next clock pulse.
// - Start with init: set clock wait, SCL held low from ninth fall.
// - Start with init itself leaves the tx buffer empty flag alone; the ninth fall still sets it.
// - Multiprocessor bit 1 marks an ID frame, 0 a data frame.
// - Interrupt enable set: no transfer, errors or flag updates until ID.
// - ID frame sets received flag, clears interrupt enable, resumes reception.
// - ID frame goes to the receive buffer and raises receive complete.
// - Multiprocessor format ignores parity; framing matches normal async mode.
// - Received flag marks buffer data as ID when 1, data when 0.
// - Multiprocessor reception uses the normal asynchronous bit clock.
// - Start: SDA falls while SCL high; stop: SDA rises while SCL high.
module sim_top (
  input  wire        clk,
  input  wire        srst,
  input  wire [2:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  input  wire        scl_in,
  output reg         scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output reg         sda_out,
  output reg         sda_oe,
  input  wire        rxd,
  output reg         ack_irq,
  output reg         nack_irq,
  output reg         rx_irq,
  output reg         dtc_req
);
  // --------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------
  wire [2:0] pins_s;
  reg        scl_d_reg;
  reg        sda_d_reg;

  sim_sync #(.WIDTH(3)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({rxd, sda_in, scl_in}),
    .sync_out (pins_s)
  );

  wire scl_s    = pins_s[0];
  wire sda_s    = pins_s[1];
  wire rxd_s    = pins_s[2];
  wire scl_rise = scl_s && !scl_d_reg;
  wire scl_fall = !scl_s && scl_d_reg;
  wire start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  wire stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // Delayed copies read only the second synchroniser stage.
  always @(posedge clk) begin
    if (srst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // ----------
  // Registers
  // ----------
  reg [15:0] ctrl_reg;
  reg [8:0]  txbuf_reg;
  reg [8:0]  rxbuf_reg;
  reg        received_multiproc_flag_reg;
  reg        fer_reg;
  reg        oer_reg;
  reg        txempty_reg;
  reg        rxdone_reg;
  reg        ack_st_reg;
  reg        nack_st_reg;
  reg        start_st_reg;
  reg        stop_st_reg;
  reg        busy_reg;
  reg [7:0]  baud_reg;
  reg [8:0]  rx_shift_reg;
  reg [8:0]  tx_shift_reg;
  reg [3:0]  bit_cnt_reg;
  reg        scl_hold_reg;

  wire two_wire  = ctrl_reg[`SIM_CTRL_TWO_WIRE];
  wire alt_order = ctrl_reg[`SIM_CTRL_ALT_ORD];
  wire ckphase   = ctrl_reg[`SIM_CTRL_CKPHASE];
  wire ack_drive = !ctrl_reg[`SIM_CTRL_AUTOCND] &&
                   ctrl_reg[`SIM_CTRL_ACK_OE];
  wire st_init   = ctrl_reg[`SIM_CTRL_STINIT];
  wire mp_fmt    = ctrl_reg[`SIM_CTRL_MPFMT];
  wire multiproc_int_enable      = ctrl_reg[`SIM_CTRL_MULTIPROC_INT_ENABLE];
  wire clk_wait  = ctrl_reg[`SIM_CTRL_CLKWAIT];
  wire [2:0] mode = ctrl_reg[`SIM_CTRL_MODE_HI:`SIM_CTRL_MODE_LO];
  wire init_go   = two_wire && start_det && st_init;
  wire wr_ctrl   = reg_wr && reg_addr == `SIM_OFF_CTRL;
  wire wr_stat   = reg_wr && reg_addr == `SIM_OFF_STATUS;
  wire rd_rxbuf  = reg_rd && reg_addr == `SIM_OFF_RXBUF;

  // ----------
  // Asynchronous multiprocessor receiver
  // ----------
  wire       arx_done;
  wire [7:0] arx_data;
  wire       arx_mp;
  wire       arx_fer;

  // Same bit timing as plain asynchronous mode; parity never enters.
  sim_async_rx u_arx (
    .clk       (clk),
    .srst      (srst),
    .rx_en     (!two_wire && mp_fmt),
    .rxd       (rxd_s),
    .eight_bit (mode == `SIM_MODE_MP8),
    .baud_div  (baud_reg),
    .done      (arx_done),
    .data      (arx_data),
    .mp_bit    (arx_mp),
    .frame_err (arx_fer)
  );

  wire arx_take = arx_done && !(multiproc_int_enable && !arx_mp);
  wire ninth_r  = two_wire && scl_rise && bit_cnt_reg == `SIM_EIGHTH_BIT;
  wire eighth_r = two_wire && scl_rise &&
                  bit_cnt_reg == (`SIM_EIGHTH_BIT - 4'h1);
  wire ninth_f  = two_wire && scl_fall && bit_cnt_reg == `SIM_NINTH_BIT;

  // --------------------------------------------------------------------
  // Control register: software writes, hardware sets clock wait and
  // clears the multiprocessor interrupt enable.
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= `SIM_CTRL_RESET;
      baud_reg <= `SIM_BAUD_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == `SIM_OFF_BAUD) begin
        baud_reg <= reg_wdata[7:0];
      end
      // Hardware updates follow the write so that they win over it.
      if (init_go) begin
        ctrl_reg[`SIM_CTRL_CLKWAIT] <= 1'b1;
      end
      if (arx_take && arx_mp && mp_fmt) begin
        ctrl_reg[`SIM_CTRL_MULTIPROC_INT_ENABLE] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Two-wire bit counter and shift registers
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      bit_cnt_reg  <= 4'h0;
      rx_shift_reg <= 9'h000;
      tx_shift_reg <= 9'h1FF;
      sda_out      <= 1'b0;
      sda_oe       <= 1'b0;
    end else if (init_go) begin
      bit_cnt_reg  <= 4'h0;
      rx_shift_reg <= 9'h000;
      tx_shift_reg <= {txbuf_reg[7:0], txbuf_reg[8]};
    end else if (two_wire) begin
      if (scl_rise) begin
        bit_cnt_reg  <= bit_cnt_reg + 4'h1;
        rx_shift_reg <= {rx_shift_reg[7:0], sda_s};
      end
      // Pin level changes only on a falling edge, so after a start the
      // level stands until the first bit is shifted out.
      if (scl_fall) begin
        if (bit_cnt_reg == `SIM_NINTH_BIT) begin
          bit_cnt_reg  <= 4'h0;
          tx_shift_reg <= {txbuf_reg[7:0], txbuf_reg[8]};
        end else begin
          tx_shift_reg <= {tx_shift_reg[7:0], 1'b1};
        end
        if (bit_cnt_reg == `SIM_EIGHTH_BIT && ack_drive) begin
          sda_oe <= !ctrl_reg[`SIM_CTRL_ACK_VAL];
        end else if (bit_cnt_reg != `SIM_NINTH_BIT) begin
          sda_oe <= !tx_shift_reg[8];
        end else begin
          sda_oe <= 1'b0;
        end
      end
      // The clock rise before a stop must not skew the next count.
      if (start_det || stop_det) begin
        bit_cnt_reg <= 4'h0;
      end
    end else begin
      bit_cnt_reg <= 4'h0;
      sda_oe      <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Clock wait: SCL pulled low from the ninth falling edge while the
  // wait bit stands; software clearing the bit frees the line.
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      scl_hold_reg <= 1'b0;
      scl_out      <= 1'b0;
      scl_oe       <= 1'b0;
    end else begin
      if (!clk_wait || !two_wire) begin
        scl_hold_reg <= 1'b0;
      end else if (ninth_f) begin
        scl_hold_reg <= 1'b1;
      end
      scl_oe <= scl_hold_reg;
    end
  end

  // --------------------------------------------------------------------
  // Receive buffer, error flags and event pulses
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      rxbuf_reg  <= 9'h000;
      received_multiproc_flag_reg   <= 1'b0;
      fer_reg    <= 1'b0;
      oer_reg    <= 1'b0;
      rxdone_reg <= 1'b0;
      rx_irq     <= 1'b0;
      ack_irq    <= 1'b0;
      nack_irq   <= 1'b0;
      dtc_req    <= 1'b0;
    end else begin
      rx_irq   <= 1'b0;
      ack_irq  <= 1'b0;
      nack_irq <= 1'b0;
      dtc_req  <= 1'b0;
      if (rd_rxbuf) begin
        rxdone_reg <= 1'b0;
      end
      // First transfer under alternate order: seven bits low, eighth high.
      if (eighth_r && alt_order) begin
        rxbuf_reg <= {sda_s, 1'b0, rx_shift_reg[6:0]};
      end
      if (ninth_r) begin
        if (!alt_order || ckphase) begin
          rxbuf_reg <= {1'b0, rx_shift_reg[7:0]};
        end
        if (!alt_order) begin
          ack_irq  <= !sda_s;
          nack_irq <= sda_s;
          dtc_req  <= !sda_s && ctrl_reg[`SIM_CTRL_ACKTRIG];
        end
        rxdone_reg <= 1'b1;
        rx_irq     <= 1'b1;
      end
      // Data frames are skipped whole while the enable waits for an ID.
      if (arx_take) begin
        rxbuf_reg  <= {1'b0, arx_data};
        received_multiproc_flag_reg   <= arx_mp;
        fer_reg    <= arx_fer;
        oer_reg    <= rxdone_reg && !rd_rxbuf;
        rxdone_reg <= 1'b1;
        rx_irq     <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Transmit buffer and status flags; a hardware set beats a status write clear, but a tx buffer write beats the tx empty set.
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      txbuf_reg    <= 9'h1FF;
      txempty_reg  <= 1'b1;
      ack_st_reg   <= 1'b0;
      nack_st_reg  <= 1'b0;
      start_st_reg <= 1'b0;
      stop_st_reg  <= 1'b0;
      busy_reg     <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `SIM_OFF_TXBUF) begin
        txbuf_reg   <= reg_wdata[8:0];
        txempty_reg <= 1'b0;
      end else if (ninth_f && !init_go) begin
        txempty_reg <= 1'b1;
      end
      if (wr_stat) begin
        ack_st_reg   <= ack_st_reg && !reg_wdata[`SIM_ST_ACK];
        nack_st_reg  <= nack_st_reg && !reg_wdata[`SIM_ST_NACK];
        start_st_reg <= start_st_reg && !reg_wdata[`SIM_ST_START];
        stop_st_reg  <= stop_st_reg && !reg_wdata[`SIM_ST_STOP];
      end
      if (ninth_r && !alt_order && !sda_s) begin
        ack_st_reg <= 1'b1;
      end
      if (ninth_r && !alt_order && sda_s) begin
        nack_st_reg <= 1'b1;
      end
      if (start_det) begin
        start_st_reg <= 1'b1;
        busy_reg     <= 1'b1;
      end
      if (stop_det) begin
        stop_st_reg <= 1'b1;
        busy_reg    <= 1'b0;
      end
    end
  end

  // ----------
  // Read port: data stand in the cycle after the strobe only.
  // ----------
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SIM_OFF_CTRL:   reg_rdata <= ctrl_reg;
        `SIM_OFF_TXBUF:  reg_rdata <= {7'h00, txbuf_reg};
        `SIM_OFF_RXBUF:  reg_rdata <= {4'h0, oer_reg, fer_reg, received_multiproc_flag_reg,
                                       rxbuf_reg};
        `SIM_OFF_STATUS: reg_rdata <= {9'h000, busy_reg, stop_st_reg,
                                       start_st_reg, nack_st_reg,
                                       ack_st_reg, rxdone_reg,
                                       txempty_reg};
        `SIM_OFF_BAUD:   reg_rdata <= {8'h00, baud_reg};
        default:         reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule // sim_top

// [tb/sim_checker.sv]
`timescale 1ns/100ps
// ----------
// Port-level checker for the serial unit
// ----------
module sim_checker (
  input logic        clk,
  input logic        srst,
  input logic [2:0]  reg_addr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic        scl_in,
  input logic        scl_out,
  input logic        scl_oe,
  input logic        sda_in,
  input logic        sda_out,
  input logic        sda_oe,
  input logic        ack_irq,
  input logic        nack_irq,
  input logic        rx_irq,
  input logic        dtc_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic       scl_q_reg;
  logic       sda_rise_reg;
  logic [3:0] fall_age_reg;
  logic [3:0] rise_age_reg;
  logic [3:0] ack_age_reg;
  // Ages since the last SCL edge and ACK pulse. The pins are seen raw,
  // so the design's synchroniser delay must fit inside the age window.
  always @(posedge clk) begin
    if (srst) begin
      scl_q_reg    <= 1'b1;
      sda_rise_reg <= 1'b1;
      fall_age_reg <= 4'hF;
      rise_age_reg <= 4'hF;
      ack_age_reg  <= 4'hF;
    end else begin
      scl_q_reg    <= scl_in;
      fall_age_reg <= (scl_q_reg && !scl_in) ? 4'h0 :
                      fall_age_reg + {3'h0, fall_age_reg != 4'hF};
      rise_age_reg <= (!scl_q_reg && scl_in) ? 4'h0 :
                      rise_age_reg + {3'h0, rise_age_reg != 4'hF};
      ack_age_reg  <= ack_irq ? 4'h0 :
                      ack_age_reg + {3'h0, ack_age_reg != 4'hF};
      if (!scl_q_reg && scl_in) begin
        sda_rise_reg <= sda_in;
      end
    end
  end
  sequence s_read_unmapped;
    reg_rd && reg_addr > 3'h4;
  endsequence
  sequence s_ack_follows;
    ##[1:4] ack_irq;
  endsequence
  chk_ack_level: assert property (ack_irq |-> !sda_rise_reg && rise_age_reg < 4'h8)
    else $error("ack pulse without low data at clock rise");
  chk_nack_level: assert property (nack_irq |-> sda_rise_reg && rise_age_reg < 4'h8)
    else $error("nack pulse without high data at clock rise");
  chk_ack_single: assert property (ack_irq |=> !ack_irq [*3])
    else $error("ack pulse too long");
  chk_rx_single: assert property (rx_irq |=> !rx_irq [*2])
    else $error("receive pulse too long");
  chk_dtc_cause: assert property (dtc_req |-> (ack_irq || ack_age_reg < 4'h5) or s_ack_follows)
    else $error("transfer request without ack");
  chk_sda_on_fall: assert property ($changed(sda_oe) |-> fall_age_reg < 4'h8)
    else $error("data drive changed away from clock fall");
  chk_wait_on_fall: assert property ($rose(scl_oe) |-> fall_age_reg < 4'h8)
    else $error("clock hold began away from clock fall");
  chk_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("open-drain output drives high");
  chk_unmapped_zero: assert property (s_read_unmapped |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside answer cycle");
endmodule // sim_checker

// [tb/sim_peer.sv]
`timescale 1ns/100ps
// ----------
// Far side: two-wire bus master and asynchronous sender
// ----------
module sim_peer (
  input  logic clk,
  input  logic sda,
  output logic scl_pull,
  output logic sda_pull,
  output logic rxd
);
  // Lines released and idle high at time zero.
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    rxd      = 1'b1;
  end
  // Half of the 320 ns link period; SCL stands still between frames.
  task automatic half;
    repeat (4) @(posedge clk);
  endtask
  // Data falls while the clock stands high.
  task automatic start_cond;
    sda_pull <= 1'b1;
    half();
    scl_pull <= 1'b1;
    half();
  endtask
  // Nine clocks MSB first; a one releases SDA so the device may drive.
  task automatic xfer(input logic [8:0] bits, output logic [8:0] seen);
    for (int i = 8; i >= 0; i--) begin
      sda_pull <= !bits[i];
      half();
      scl_pull <= 1'b0;
      repeat (2) @(posedge clk);
      seen[i] = sda;
      repeat (2) @(posedge clk);
      scl_pull <= 1'b1;
    end
  endtask
  // Data rises while the clock stands high; both lines left released.
  task automatic stop_cond;
    sda_pull <= 1'b1;
    half();
    scl_pull <= 1'b0;
    half();
    sda_pull <= 1'b0;
    half();
  endtask
  // Frame LSB first, then the multiprocessor bit and stop; bit time is
  // eight clocks, so the bench must program a divider of 7.
  task automatic frame(input logic [7:0] d, input logic mp,
                       input logic eight);
    logic [9:0] bits;
    bits = eight ? {1'b1, mp, d} : {2'b11, mp, d[6:0]};
    rxd <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rxd <= bits[i];
      repeat (8) @(posedge clk);
    end
  endtask
endmodule // sim_peer

// [tb/testbench.sv]
`timescale 1ns/100ps
`include "sim_regs.vh"
// ----------
// Self-checking bench for the serial unit
// ----------
module testbench;
  logic        clk, srst, reg_wr, reg_rd;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v, w;
  logic        scl_out, scl_oe, sda_out, sda_oe, rxd;
  logic        ack_irq, nack_irq, rx_irq, dtc_req, scl_pull, sda_pull;
  logic [8:0]  seen;
  logic [7:0]  d, id, mk;
  logic        a;
  int          err_total, checks, n_ack, n_nack, n_rx, n_dtc;
  int          b_ack, b_nack, b_rx, b_dtc;
  // Open-drain lines with pull-ups.
  wire         scl = !(scl_oe || scl_pull);
  wire         sda = !(sda_oe || sda_pull);

  sim_top i_sim_top (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .rxd(rxd), .ack_irq(ack_irq), .nack_irq(nack_irq), .rx_irq(rx_irq),
    .dtc_req(dtc_req));
  sim_peer u_peer (.clk(clk), .sda(sda), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .rxd(rxd));

  always #20 clk = ~clk;
  // Pulse counters; tests compare differences across one transfer.
  always @(posedge clk) begin
    n_ack  <= n_ack + int'(ack_irq === 1'b1);
    n_nack <= n_nack + int'(nack_irq === 1'b1);
    n_rx   <= n_rx + int'(rx_irq === 1'b1);
    n_dtc  <= n_dtc + int'(dtc_req === 1'b1);
  end
  task automatic finish_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_n(input int got, input int exp);
    checks++;
    if (got != exp) begin
      err_total++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] ad, input logic [15:0] wd);
    @(posedge clk);
    reg_addr  <= ad;
    reg_wdata <= wd;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is taken once settled.
  task automatic rd(input logic [2:0] ad, output logic [15:0] rv);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic wait_rx(input int n);
    int t;
    t = 0;
    while (n_rx < n && t < 200) begin
      @(posedge clk);
      t++;
    end
    cmp_n(n_rx, n);
    if (n_rx < n) begin
      finish_test();
    end
  endtask
  // One bus transfer framed by start and stop; leaves the buffer in v.
  task automatic two_wire(input logic [15:0] ctrl, input logic [8:0] bits);
    wr(`SIM_OFF_CTRL, ctrl);
    b_ack  = n_ack;
    b_nack = n_nack;
    b_rx   = n_rx;
    b_dtc  = n_dtc;
    u_peer.start_cond();
    u_peer.xfer(bits, seen);
    u_peer.stop_cond();
    repeat (8) @(posedge clk);
    rd(`SIM_OFF_RXBUF, v);
  endtask
  function automatic logic [15:0] exp_rx(input logic [7:0] dd,
                                         input logic alt, input logic ph);
    exp_rx = (alt && !ph) ? {7'h00, dd[0], 1'b0, dd[7:1]} : {8'h00, dd};
  endfunction
  // A hang is cut short and counted.
  initial begin
    repeat (100000) @(posedge clk);
    cmp_n(0, 1);
    finish_test();
  end
  initial begin
    clk = 0; srst = 1; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0;
    err_total = 0; checks = 0; n_ack = 0; n_nack = 0; n_rx = 0; n_dtc = 0;
    void'($urandom(92));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    rd(`SIM_OFF_CTRL, v); cmp(v, `SIM_CTRL_RESET);
    rd(`SIM_OFF_BAUD, v); cmp(v, {8'h00, `SIM_BAUD_RESET});
    rd(`SIM_OFF_TXBUF, v); cmp(v, 16'h01FF);
    wr(3'h6, 16'hFFFF);
    rd(3'h6, v); cmp(v, 16'h0000);
    wr(`SIM_OFF_BAUD, 16'h0007);
    rd(`SIM_OFF_BAUD, v); cmp(v, 16'h0007);
    $display("test registers done");
    // Every order and phase setting; ack trigger only in normal order.
    for (int k = 0; k < 4; k++) begin
      d = $urandom;
      a = $urandom;
      two_wire({8'h00, !k[0], 4'h0, k[1], k[0], 1'b1}, {d, a});
      cmp(v & ((k[0] && !k[1]) ? 16'h01FF : 16'h00FF), exp_rx(d, k[0], k[1]));
      cmp_n(n_rx - b_rx, 1);
      if (!k[0]) begin
        cmp_n(n_ack - b_ack, !a);
        cmp_n(n_nack - b_nack, a);
        cmp_n(n_dtc - b_dtc, !a);
      end
      rd(`SIM_OFF_STATUS, v); cmp(v & 16'h0030, 16'h0030);
      wr(`SIM_OFF_STATUS, `SIM_ST_W1C_MASK);
    end
    $display("test receive layout done");
    // Device drives its ack value in the ninth bit.
    for (int k = 0; k < 2; k++) begin
      two_wire({10'h000, k[0], 5'h11}, 9'h1FF);
      cmp_n(seen[0], k);
      cmp_n(n_ack - b_ack, 1 - k);
    end
    $display("test ack output done");
    d = $urandom;
    wr(`SIM_OFF_CTRL, 16'h0441);
    wr(`SIM_OFF_TXBUF, {8'h00, d});
    rd(`SIM_OFF_STATUS, w);
    u_peer.start_cond();
    rd(`SIM_OFF_STATUS, v); cmp(v & 16'h0001, w & 16'h0001);
    u_peer.xfer(9'h1FF, seen);
    cmp({8'h00, seen[8:1]}, {8'h00, d});
    repeat (8) @(posedge clk);
    cmp({15'h0000, scl_oe}, 16'h0001);
    rd(`SIM_OFF_CTRL, v); cmp(v & 16'h0800, 16'h0800);
    rd(`SIM_OFF_RXBUF, v); cmp(v & 16'h00FF, {8'h00, d});
    wr(`SIM_OFF_CTRL, 16'h0441);
    repeat (4) @(posedge clk);
    cmp({15'h0000, scl_oe}, 16'h0000);
    u_peer.stop_cond();
    $display("test start init done");
    // Seven- then eight-bit frames: skipped data, ID, accepted data.
    for (int m = 0; m < 2; m++) begin
      d = $urandom;
      id = $urandom;
      mk = m ? 8'hFF : 8'h7F;
      wr(`SIM_OFF_CTRL, {1'b0, 2'b10, m[0], 2'b00, 2'b11, 8'h00});
      b_rx = n_rx;
      u_peer.frame(d, 1'b0, m[0]);
      repeat (16) @(posedge clk);
      cmp_n(n_rx - b_rx, 0);
      rd(`SIM_OFF_CTRL, v); cmp(v & 16'h0200, 16'h0200);
      u_peer.frame(id, 1'b1, m[0]);
      wait_rx(b_rx + 1);
      rd(`SIM_OFF_RXBUF, v);
      cmp(v & {8'h06, mk}, {8'h02, id & mk});
      rd(`SIM_OFF_CTRL, v); cmp(v & 16'h0200, 16'h0000);
      u_peer.frame(d, 1'b0, m[0]);
      wait_rx(b_rx + 2);
      rd(`SIM_OFF_RXBUF, v); cmp(v & {8'h06, mk}, {8'h00, d & mk});
    end
    $display("test multiprocessor done");
    finish_test();
  end
endmodule // testbench

bind sim_top sim_checker u_chk (.clk(clk), .srst(srst),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .ack_irq(ack_irq),
  .nack_irq(nack_irq), .rx_irq(rx_irq), .dtc_req(dtc_req));
